// ### pifb_consts.svh
// register offsets, field positions and reset values of the interrupt flag bank
`ifndef PIFB_CONSTS_SVH
`define PIFB_CONSTS_SVH

`define PIFB_ADDR_W 5
`define PIFB_OFS_CONTROL 5'h00
`define PIFB_OFS_ENABLE0 5'h01
`define PIFB_OFS_REQUEST0 5'h09
`define PIFB_OFS_STATUS 5'h11
`define PIFB_OFS_MASK 5'h12
`define PIFB_REG_NUM 8
`define PIFB_REG_IDX_W 3

`define PIFB_BIT_GLOBAL_EN 7
`define PIFB_BIT_PERIPH_EN 6
`define PIFB_BIT_EDGE 0
`define PIFB_CONTROL_MASK 8'hc1

`define PIFB_REQ0_MASK 8'h31
`define PIFB_REQ1_MASK 8'hc1
`define PIFB_REQ2_MASK 8'h43
`define PIFB_REQ3_MASK 8'hf3
`define PIFB_REQ4_MASK 8'h03
`define PIFB_REQ5_MASK 8'hf1
`define PIFB_REQ6_MASK 8'h03
`define PIFB_REQ7_MASK 8'h31

`define PIFB_BIT_CAPCMP_A 0
`define PIFB_BIT_CAPCMP_B 1
`define PIFB_BIT_WAVE_SHUT 0
`define PIFB_BIT_OSC_ROLL 4
`define PIFB_BIT_NVM_DONE 5

`define PIFB_MODE_CAPTURE 2'h0
`define PIFB_MODE_COMPARE 2'h1
`define PIFB_MODE_PWM 2'h2

`define PIFB_STAT_W 2
`define PIFB_STAT_BIT_FLAG 0
`define PIFB_STAT_BIT_CPU 1

`define PIFB_RESET_BYTE 8'h00
`define PIFB_RESET_WORD 32'h0000_0000
`define PIFB_RESET_STAT 2'h0
`define PIFB_RESP_OKAY 2'h0
`define PIFB_RESP_DECERR 2'h2

`endif

// ### pifb_pkg.sv
// types shared by the interrupt flag bank
package pifb_pkg;
  typedef logic [7:0] pifb_byte_t;
  typedef enum logic [1:0] {
    PIFB_CAPTURE,
    PIFB_COMPARE,
    PIFB_PWM,
    PIFB_OFF
  } pifb_mode_e;
endpackage

// ### pifb_flag_bank.sv
// peripheral interrupt flag and enable register bank with avalon-mm slave
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pifb_consts.svh"
// What this block does
// - flags set on their event regardless of any enable bit
// - capcmp flags set on capture, compare match or pwm trailing edge, whichever the unit's mode select picks; none in the fourth mode
// - nvm done flag bit 5 set on completion, stays until cleared
// - oscillator flag bit 4 set on every accumulator rollover
// - waveform flag bit 0 set on entering shutdown only, stays until cleared
// - unimplemented request bits read zero and ignore writes
// - implemented flags hardware set, software read/write, reset to zero
module pifb_flag_bank (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [7:0] periph_event_0,
  input wire logic [7:0] periph_event_1,
  input wire logic [7:0] periph_event_2,
  input wire logic [7:0] periph_event_3,
  input wire logic [7:0] periph_event_4,
  input wire logic [7:0] periph_event_5,
  input wire logic [1:0] capcmp_a_mode_select,
  input wire logic capcmp_a_capture,
  input wire logic capcmp_a_match,
  input wire logic capcmp_a_trailing,
  input wire logic [1:0] capcmp_b_mode_select,
  input wire logic capcmp_b_capture,
  input wire logic capcmp_b_match,
  input wire logic capcmp_b_trailing,
  input wire logic nvm_done,
  input wire logic osc_rollover,
  input wire logic waveform_shutdown,
  output logic cpu_irq,
  output logic ext_irq_edge_select,
  output logic irq
);

  pifb_pkg::pifb_byte_t control_ff;
  pifb_pkg::pifb_byte_t enable_ff [`PIFB_REG_NUM];
  pifb_pkg::pifb_byte_t request_ff [`PIFB_REG_NUM];
  logic [`PIFB_STAT_W-1:0] status_ff;
  logic [`PIFB_STAT_W-1:0] mask_ff;
  logic ack_ff;
  logic waitreq_ff;
  logic [31:0] avs_readdata_ff;
  logic [31:0] nxt_readdata;
  logic [1:0] avs_response_ff;
  logic cpu_irq_ff;
  logic irq_ff;
  logic any_req_ff;
  logic shutdown_prev_ff;
  logic [7:0] event_vec [`PIFB_REG_NUM];
  logic [7:0] nxt_event [`PIFB_REG_NUM];
  logic nxt_any_req;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [`PIFB_STAT_W-1:0] stat_evt;

  // implemented positions of each request and enable register
  function automatic logic [7:0] impl_mask(input logic [`PIFB_REG_IDX_W-1:0] idx);
    logic [7:0] m;
    m = `PIFB_REQ0_MASK;
    case (idx)
      3'h0: m = `PIFB_REQ0_MASK;
      3'h1: m = `PIFB_REQ1_MASK;
      3'h2: m = `PIFB_REQ2_MASK;
      3'h3: m = `PIFB_REQ3_MASK;
      3'h4: m = `PIFB_REQ4_MASK;
      3'h5: m = `PIFB_REQ5_MASK;
      3'h6: m = `PIFB_REQ6_MASK;
      default: m = `PIFB_REQ7_MASK;
    endcase
    return m;
  endfunction

  // event of one capture/compare unit in its current mode
  function automatic logic capcmp_event(input logic [1:0] mode, input logic cap,
                                        input logic cmp, input logic trail);
    logic e;
    e = 1'b0;
    if (mode == `PIFB_MODE_CAPTURE)
    begin
      e = cap;
    end
    else if (mode == `PIFB_MODE_COMPARE)
    begin
      e = cmp;
    end
    else if (mode == `PIFB_MODE_PWM)
    begin
      e = trail;
    end
    return e;
  endfunction

  // enable words form one block of eight
  function automatic logic in_enable_range(input logic [`PIFB_ADDR_W-1:0] a);
    return a >= `PIFB_OFS_ENABLE0 && a < `PIFB_OFS_REQUEST0;
  endfunction

  // request words follow the enable block
  function automatic logic in_request_range(input logic [`PIFB_ADDR_W-1:0] a);
    return a >= `PIFB_OFS_REQUEST0 && a < `PIFB_OFS_STATUS;
  endfunction

  // both blocks start one past a multiple of eight
  function automatic logic [`PIFB_REG_IDX_W-1:0] reg_slot(input logic [`PIFB_ADDR_W-1:0] a);
    logic [`PIFB_ADDR_W-1:0] d;
    d = a - `PIFB_OFS_ENABLE0;
    return d[`PIFB_REG_IDX_W-1:0];
  endfunction

  // words from control up to mask answer, the rest is a decode error
  function automatic logic is_mapped(input logic [`PIFB_ADDR_W-1:0] a);
    return a <= `PIFB_OFS_MASK;
  endfunction

  // request taken at the edge that still sees waitrequest high
  assign wr_en = avs_write && !ack_ff;
  assign wr_byte = avs_byteenable[0] ? avs_writedata[7:0] : `PIFB_RESET_BYTE;

  // per-register event vectors
  always_comb
  begin
    nxt_event[0] = periph_event_0;
    nxt_event[1] = periph_event_1;
    nxt_event[2] = periph_event_2;
    nxt_event[3] = periph_event_3;
    nxt_event[4] = periph_event_4;
    nxt_event[5] = periph_event_5;
    nxt_event[6] = `PIFB_RESET_BYTE;
    nxt_event[7] = `PIFB_RESET_BYTE;
    nxt_event[6][`PIFB_BIT_CAPCMP_A] = capcmp_event(capcmp_a_mode_select, capcmp_a_capture,
                                                    capcmp_a_match, capcmp_a_trailing);
    nxt_event[6][`PIFB_BIT_CAPCMP_B] = capcmp_event(capcmp_b_mode_select, capcmp_b_capture,
                                                    capcmp_b_match, capcmp_b_trailing);
    nxt_event[7][`PIFB_BIT_NVM_DONE] = nvm_done;
    nxt_event[7][`PIFB_BIT_OSC_ROLL] = osc_rollover;
    // shutdown entry is the rising edge of the shutdown level
    nxt_event[7][`PIFB_BIT_WAVE_SHUT] = waveform_shutdown && !shutdown_prev_ff;
    for (int i = 0; i < `PIFB_REG_NUM; i++)
    begin
      event_vec[i] = nxt_event[i] & impl_mask(i[`PIFB_REG_IDX_W-1:0]);
    end
  end

  // last shutdown level, for entry detection
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shutdown_prev_ff <= 1'b0;
    end
    else
    begin
      shutdown_prev_ff <= waveform_shutdown;
    end
  end

  // flags: hardware set beats software write in the same cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `PIFB_REG_NUM; i++)
      begin
        request_ff[i] <= `PIFB_RESET_BYTE;
      end
    end
    else
    begin
      for (int i = 0; i < `PIFB_REG_NUM; i++)
      begin
        if (wr_en && avs_byteenable[0] && in_request_range(avs_address) &&
            reg_slot(avs_address) == i[`PIFB_REG_IDX_W-1:0])
        begin
          request_ff[i] <= (wr_byte | event_vec[i]) &
                           impl_mask(i[`PIFB_REG_IDX_W-1:0]);
        end
        else
        begin
          request_ff[i] <= request_ff[i] | event_vec[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `PIFB_REG_NUM; i++)
      begin
        enable_ff[i] <= `PIFB_RESET_BYTE;
      end
    end
    else
    begin
      for (int i = 0; i < `PIFB_REG_NUM; i++)
      begin
        if (wr_en && avs_byteenable[0] && in_enable_range(avs_address) &&
            reg_slot(avs_address) == i[`PIFB_REG_IDX_W-1:0])
        begin
          enable_ff[i] <= wr_byte & impl_mask(i[`PIFB_REG_IDX_W-1:0]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      control_ff <= `PIFB_RESET_BYTE;
      mask_ff <= `PIFB_RESET_STAT;
    end
    else if (wr_en && avs_byteenable[0])
    begin
      if (avs_address == `PIFB_OFS_CONTROL)
      begin
        control_ff <= wr_byte & `PIFB_CONTROL_MASK;
      end
      else if (avs_address == `PIFB_OFS_MASK)
      begin
        mask_ff <= wr_byte[`PIFB_STAT_W-1:0];
      end
    end
  end

  // request when any flag meets its enable
  always_comb
  begin
    nxt_any_req = 1'b0;
    for (int i = 0; i < `PIFB_REG_NUM; i++)
    begin
      nxt_any_req = nxt_any_req | (|(request_ff[i] & enable_ff[i]));
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      any_req_ff <= 1'b0;
      cpu_irq_ff <= 1'b0;
    end
    else
    begin
      any_req_ff <= nxt_any_req;
      cpu_irq_ff <= nxt_any_req && control_ff[`PIFB_BIT_GLOBAL_EN] &&
                    control_ff[`PIFB_BIT_PERIPH_EN];
    end
  end

  // sticky status: bit0 pending request, bit1 cpu interrupt raised
  assign stat_evt = {cpu_irq_ff, any_req_ff};

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_ff <= `PIFB_RESET_STAT;
    end
    else if (wr_en && avs_byteenable[0] && avs_address == `PIFB_OFS_STATUS)
    begin
      status_ff <= (status_ff & ~wr_byte[`PIFB_STAT_W-1:0]) | stat_evt;
    end
    else
    begin
      status_ff <= status_ff | stat_evt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // bus slave: one wait cycle, then answer; waitrequest has a flop of its own
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_ff <= 1'b0;
      waitreq_ff <= 1'b1;
    end
    else
    begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      waitreq_ff <= !((avs_read || avs_write) && !ack_ff);
    end
  end

  // read mux over the register words
  always_comb
  begin
    nxt_readdata = `PIFB_RESET_WORD;
    // unmapped words read as zero
    if (avs_address == `PIFB_OFS_CONTROL)
    begin
      nxt_readdata[7:0] = control_ff;
    end
    else if (in_enable_range(avs_address))
    begin
      nxt_readdata[7:0] = enable_ff[reg_slot(avs_address)];
    end
    else if (in_request_range(avs_address))
    begin
      nxt_readdata[7:0] = request_ff[reg_slot(avs_address)];
    end
    else if (avs_address == `PIFB_OFS_STATUS)
    begin
      nxt_readdata[`PIFB_STAT_W-1:0] = status_ff;
    end
    else if (avs_address == `PIFB_OFS_MASK)
    begin
      nxt_readdata[`PIFB_STAT_W-1:0] = mask_ff;
    end
  end

  // read data captured on the taking edge, held until the next request
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_readdata_ff <= `PIFB_RESET_WORD;
    end
    else if ((avs_read || avs_write) && !ack_ff)
    begin
      avs_readdata_ff <= nxt_readdata;
    end
  end

  // response code captured with the read data
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_response_ff <= `PIFB_RESP_OKAY;
    end
    else if ((avs_read || avs_write) && !ack_ff)
    begin
      avs_response_ff <= is_mapped(avs_address) ? `PIFB_RESP_OKAY : `PIFB_RESP_DECERR;
    end
  end

  assign avs_readdata = avs_readdata_ff;
  assign avs_response = avs_response_ff;
  assign avs_waitrequest = waitreq_ff;
  assign cpu_irq = cpu_irq_ff;
  assign irq = irq_ff;
  assign ext_irq_edge_select = control_ff[`PIFB_BIT_EDGE];

endmodule // pifb_flag_bank
`default_nettype wire

// ### pifb_periph_model.sv
// peripheral event source model driving the flag bank event inputs
`timescale 1ns/100ps
`default_nettype none
module pifb_periph_model (
  input wire logic sys_clk,
  output logic [7:0] periph_event_0,
  output logic [7:0] periph_event_1,
  output logic [7:0] periph_event_2,
  output logic [7:0] periph_event_3,
  output logic [7:0] periph_event_4,
  output logic [7:0] periph_event_5,
  output logic [1:0] capcmp_a_mode_select,
  output logic [1:0] capcmp_b_mode_select,
  output logic [7:0] strobe,
  output logic waveform_shutdown
);
  logic [7:0] ev [6] = '{default: 8'h00};
  assign periph_event_0 = ev[0];
  assign periph_event_1 = ev[1];
  assign periph_event_2 = ev[2];
  assign periph_event_3 = ev[3];
  assign periph_event_4 = ev[4];
  assign periph_event_5 = ev[5];
  initial
  begin
    strobe = 8'h00;
    waveform_shutdown = 1'b0;
    capcmp_a_mode_select = 2'h3;
    capcmp_b_mode_select = 2'h3;
  end
  // one-cycle event pulse, sources 0..5 then the strobe group
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge sys_clk);
    if (k < 6)
      ev[k] <= v;
    else
      strobe <= v;
    @(posedge sys_clk);
    ev <= '{default: 8'h00};
    strobe <= 8'h00;
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(posedge sys_clk);
    capcmp_a_mode_select <= m;
    capcmp_b_mode_select <= m;
  endtask
  task automatic set_shut(input logic v);
    @(posedge sys_clk);
    waveform_shutdown <= v;
  endtask
endmodule // pifb_periph_model
`default_nettype wire

// ### pifb_flag_bank_chk.sv
// bus and interrupt output assertions for the flag bank
`timescale 1ns/100ps
`default_nettype none
`include "pifb_consts.svh"
module pifb_flag_bank_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic cpu_irq,
  input wire logic ext_irq_edge_select,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic ans;
  assign ans = (avs_read || avs_write) && !avs_waitrequest;
  property p_one_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest low two cycles");
  property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("request not answered in one cycle");
  property p_no_spur; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without request");
  property p_upper; ans |-> avs_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("readdata upper bits set");
  property p_req6;
    ans && avs_read && avs_address == `PIFB_OFS_REQUEST0 + 5'h6
      |-> (avs_readdata[7:0] & ~`PIFB_REQ6_MASK) == 8'h00;
  endproperty
  a_req6: assert property (p_req6) else $error("unimplemented bit read one");
  property p_req7;
    ans && avs_read && avs_address == `PIFB_OFS_REQUEST0 + 5'h7
      |-> (avs_readdata[7:0] & ~`PIFB_REQ7_MASK) == 8'h00;
  endproperty
  a_req7: assert property (p_req7) else $error("unimplemented bit read one");
  property p_unmapped;
    ans && avs_read && avs_address > `PIFB_OFS_MASK |-> avs_response == 2'h2 && avs_readdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_mapped; ans && avs_address <= `PIFB_OFS_MASK |-> avs_response == 2'h0; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_reset; $rose(resetn) |-> !cpu_irq && !irq && !ext_irq_edge_select; endproperty
  a_reset: assert property (p_reset) else $error("output set after reset");
  c_read: cover property (ans && avs_read);
  c_cpu: cover property ($rose(cpu_irq));
  c_irq: cover property ($rose(irq));
endmodule // pifb_flag_bank_chk
`default_nettype wire

// ### pifb_flag_bank_bench.sv
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/100ps
`default_nettype none
`include "pifb_consts.svh"
module pifb_flag_bank_bench;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest, cpu_irq, irq, ext_irq_edge_select;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] avs_response, rsp, capcmp_a_mode_select, capcmp_b_mode_select;
  logic [7:0] periph_event_0, periph_event_1, periph_event_2, periph_event_3, periph_event_4;
  logic [7:0] periph_event_5, strobe;
  logic waveform_shutdown;
  int miscompares, checks;
  logic [7:0] mk [8] = '{`PIFB_REQ0_MASK, `PIFB_REQ1_MASK, `PIFB_REQ2_MASK, `PIFB_REQ3_MASK,
    `PIFB_REQ4_MASK, `PIFB_REQ5_MASK, `PIFB_REQ6_MASK, `PIFB_REQ7_MASK};
  pifb_flag_bank i_pifb_flag_bank (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .avs_response,
    .periph_event_0, .periph_event_1, .periph_event_2, .periph_event_3, .periph_event_4,
    .periph_event_5, .capcmp_a_mode_select, .capcmp_a_capture(strobe[0]),
    .capcmp_a_match(strobe[1]), .capcmp_a_trailing(strobe[2]), .capcmp_b_mode_select,
    .capcmp_b_capture(strobe[3]), .capcmp_b_match(strobe[4]), .capcmp_b_trailing(strobe[5]),
    .nvm_done(strobe[6]), .osc_rollover(strobe[7]), .waveform_shutdown, .cpu_irq,
    .ext_irq_edge_select, .irq);
  pifb_periph_model i_pifb_periph_model (.sys_clk, .periph_event_0, .periph_event_1,
    .periph_event_2, .periph_event_3, .periph_event_4, .periph_event_5, .capcmp_a_mode_select,
    .capcmp_b_mode_select, .strobe, .waveform_shutdown);
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    repeat (20)
    begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    q = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask
  task automatic wait_out();
    repeat (3) @(negedge sys_clk);
  endtask
  initial
  begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    miscompares = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int r = 0; r <= 'h13; r++)
      rd(r[4:0], 8'h00, "reset value");
    chk("unmapped response", 32'h2, {30'h0, rsp});
    $display("test reset values done");
    for (int r = 0; r < 8; r++)
    begin
      acc(1'b1, `PIFB_OFS_REQUEST0 + r[4:0], 8'hff);
      rd(`PIFB_OFS_REQUEST0 + r[4:0], mk[r], "request implemented bits");
      acc(1'b1, `PIFB_OFS_REQUEST0 + r[4:0], 8'h00);
      rd(`PIFB_OFS_REQUEST0 + r[4:0], 8'h00, "request cleared");
    end
    acc(1'b1, `PIFB_OFS_CONTROL, 8'hff);
    rd(`PIFB_OFS_CONTROL, `PIFB_CONTROL_MASK, "control");
    wait_out();
    chk("edge select", 32'h1, {31'h0, ext_irq_edge_select});
    acc(1'b1, `PIFB_OFS_CONTROL, 8'h00);
    $display("test unimplemented bits done");
    for (int r = 0; r < 6; r++)
    begin
      i_pifb_periph_model.pulse(r, 8'hff);
      rd(`PIFB_OFS_REQUEST0 + r[4:0], mk[r], "event flags");
      acc(1'b1, `PIFB_OFS_REQUEST0 + r[4:0], 8'h00);
    end
    for (int m = 0; m < 3; m++)
    begin
      i_pifb_periph_model.set_mode(m[1:0]);
      i_pifb_periph_model.pulse(6, 8'h3f & ~(8'h09 << m));
      rd(`PIFB_OFS_REQUEST0 + 5'h6, 8'h00, "capcmp strobes of other modes");
      i_pifb_periph_model.pulse(6, 8'h09 << m);
      rd(`PIFB_OFS_REQUEST0 + 5'h7 - 5'h1, 8'h03, "capcmp flags");
      acc(1'b1, `PIFB_OFS_REQUEST0 + 5'h6, 8'h00);
    end
    i_pifb_periph_model.pulse(6, 8'h40);
    wait_out();
    rd(`PIFB_OFS_REQUEST0 + 5'h7, 8'h20, "nvm flag");
    rd(`PIFB_OFS_REQUEST0 + 5'h7, 8'h20, "nvm flag held");
    acc(1'b1, `PIFB_OFS_REQUEST0 + 5'h7, 8'h00);
    i_pifb_periph_model.pulse(6, 8'h80);
    rd(`PIFB_OFS_REQUEST0 + 5'h7, 8'h10, "rollover flag");
    acc(1'b1, `PIFB_OFS_REQUEST0 + 5'h7, 8'h00);
    i_pifb_periph_model.set_shut(1'b1);
    rd(`PIFB_OFS_REQUEST0 + 5'h7, 8'h01, "shutdown flag");
    acc(1'b1, `PIFB_OFS_REQUEST0 + 5'h7, 8'h00);
    rd(`PIFB_OFS_REQUEST0 + 5'h7, 8'h00, "shutdown flag cleared");
    i_pifb_periph_model.set_shut(1'b0);
    $display("test event flags done");
    acc(1'b1, `PIFB_OFS_ENABLE0 + 5'h6, 8'h02);
    acc(1'b1, `PIFB_OFS_CONTROL, 8'hc0);
    // units are still in pwm mode: strobe bit 2 is unit a's trailing edge
    i_pifb_periph_model.pulse(6, 8'h04);
    wait_out();
    chk("cpu_irq other enable", 32'h0, {31'h0, cpu_irq});
    rd(`PIFB_OFS_REQUEST0 + 5'h6, 8'h01, "flag without enable");
    acc(1'b1, `PIFB_OFS_REQUEST0 + 5'h6, 8'h00);
    acc(1'b1, `PIFB_OFS_ENABLE0 + 5'h6, 8'h01);
    i_pifb_periph_model.pulse(6, 8'h04);
    wait_out();
    chk("cpu_irq", 32'h1, {31'h0, cpu_irq});
    rd(`PIFB_OFS_STATUS, 8'h03, "status");
    acc(1'b1, `PIFB_OFS_MASK, 8'h01);
    wait_out();
    chk("irq unmasked", 32'h1, {31'h0, irq});
    acc(1'b1, `PIFB_OFS_MASK, 8'h00);
    wait_out();
    chk("irq masked", 32'h0, {31'h0, irq});
    acc(1'b1, `PIFB_OFS_MASK, 8'h01);
    acc(1'b1, `PIFB_OFS_CONTROL, 8'h40);
    wait_out();
    chk("cpu_irq global off", 32'h0, {31'h0, cpu_irq});
    acc(1'b1, `PIFB_OFS_REQUEST0 + 5'h6, 8'h00);
    acc(1'b1, `PIFB_OFS_STATUS, 8'h03);
    rd(`PIFB_OFS_STATUS, 8'h00, "status cleared");
    wait_out();
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt path done");
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end
endmodule // pifb_flag_bank_bench
bind pifb_flag_bank pifb_flag_bank_chk i_pifb_flag_bank_chk (.sys_clk, .resetn, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .cpu_irq,
  .ext_irq_edge_select, .irq);
`default_nettype wire
